// ---- core/pad_ioc.sv ----
// Port B pad controls and port C edge change detection behind an AHB-Lite slave
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module pad_ioc
   import pad_ioc_pkg::*;
#(
   parameter int PINS = 8                            // Pins per port
)
(
   input  wire logic              hclk,              // System clock, 200 MHz
   input  wire logic              hresetn,           // Asynchronous reset, active low
   input  wire logic              clk_en,            // Freezes all state while low
   input  wire logic              hsel,              // Slave select
   input  wire logic [7:0]        haddr,             // Byte address
   input  wire logic [1:0]        htrans,            // Transfer type
   input  wire logic              hwrite,            // Write when high
   input  wire logic [2:0]        hsize,             // Transfer size
   input  wire logic              hready,            // Bus ready in
   input  wire logic [31:0]       hwdata,            // Write data
   output logic [31:0]            hrdata,            // Read data
   output logic                   hreadyout,         // Slave ready
   output logic                   hresp,             // Always OKAY
   input  wire logic [PINS-1:0]   portb_ttl_in,      // Port B pads, TTL buffers
   input  wire logic [PINS-1:0]   portb_st_in,       // Port B pads, Schmitt buffers
   input  wire logic [PINS-1:0]   portc_in,          // Port C pads
   output logic [PINS-1:0]        portb_data,        // Port B synchronised read value
   output logic [PINS-1:0]        portb_threshold_sel, // Threshold select to pads
   output logic                   pin1_strong_drive_en, // High drive on port B pin 1
   output logic [PINS-1:0]        pin_change_flag,   // Per-pin change flags
   output logic                   change_summary_flag, // Any change flag set
   output logic                   irq                // Level interrupt
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (PINS != REG_W)
   begin : g_bad_width
      $error("pad_ioc: PINS must equal the register width");
   end

   // ---------------------------------------------------------------
   // Behaviour notes
   // ---------------------------------------------------------------
   // Register map, one aligned word each, data in bits 7:0 and zero above:
   //   0x00 threshold select, one bit per port B pin, resets to all Schmitt
   //   0x04 strong drive, only bit 1 is kept, every other bit reads zero
   //   0x08 rising-edge enables and 0x0c falling-edge enables for port C
   //   0x10 per-pin change flags, write one to clear
   //   0x14 interrupt status, bit 0 set by any armed edge, write one to clear
   //   0x18 interrupt mask, bit 0 lets the status bit drive the interrupt
   //   0x1c synchronised port C level, read only
   // Unmapped addresses read zero and ignore writes.
   //
   // Bus timing: the slave never inserts a wait state. A write lands at the
   // edge that ends its data phase, so a read issued back to back with a write
   // to the same register still returns the old value; leave one idle cycle.
   // Read data is chosen from the address phase and held for the data phase.
   // Transfers that are not aligned words are treated as unmapped.
   //
   // Pin timing: a pad change reaches the second synchroniser stage two edges
   // later and the edge compare fires on the third, which is when the flag and
   // its output copy load together. Pulses shorter than one clock can be lost;
   // software that needs them must slow the pads down instead.
   //
   // Port C pin 5 has no change detection: its enable bits are dropped at the
   // write and masked again at the read, so neither path can bring one back.
   //
   // The summary flag is the OR of the pin flags, so it falls only when the last
   // pin flag is cleared. The status bit is a separate sticky copy for the
   // interrupt, cleared on its own.
   //
   // While the clock enable is low every flop holds, synchronisers included;
   // a pad that toggles and returns during that time leaves no flag.

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [PINS-1:0] thr_q;
   logic [PINS-1:0] drv_q;
   logic [PINS-1:0] rise_q;
   logic [PINS-1:0] fall_q;
   logic [PINS-1:0] flag_q;
   logic [PINS-1:0] flag_d;
   logic [0:0]      stat_q;
   logic [0:0]      stat_d;
   logic [0:0]      mask_q;
   logic [PINS-1:0] b_sel;
   logic [PINS-1:0] b_ttl_meta_q;
   logic [PINS-1:0] b_ttl_sync_q;
   logic [PINS-1:0] b_st_meta_q;
   logic [PINS-1:0] b_st_sync_q;
   logic [PINS-1:0] c_meta_q;
   logic [PINS-1:0] c_sync_q;
   logic [PINS-1:0] c_prev_q;
   logic [PINS-1:0] edge_hit;
   logic            edge_any;
   logic            wr_pend_q;
   logic [7:0]      wr_addr_q;
   logic            irq_q;
   logic            ready_q;
   logic            resp_q;
   logic [31:0]     rdata_q;
   logic            a_valid;
   logic            a_ok;
   logic            do_rd;
   logic [7:0]      wd;
   logic            wr_thr;
   logic            wr_drv;
   logic            wr_rise;
   logic            wr_fall;
   logic            wr_flag;
   logic            wr_stat;
   logic            wr_mask;
   logic [PINS-1:0] rd_sel;
   logic [31:0]     rdata_d;

   // ---------------------------------------------------------------
   // Address phase decode
   // ---------------------------------------------------------------
   // Only aligned word transfers are honoured; others act as unmapped
   assign a_valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   assign a_ok    = a_valid && (hsize == HSIZE_WORD) && (haddr[1:0] == ADDR_LSB_ZERO);
   assign do_rd   = a_ok && !hwrite;
   assign wd      = hwdata[7:0];

   // Write data arrives one cycle after the address, so strobes use the held address
   assign wr_thr  = wr_pend_q && (wr_addr_q == ADDR_THRESHOLD_SEL);
   assign wr_drv  = wr_pend_q && (wr_addr_q == ADDR_STRONG_DRIVE);
   assign wr_rise = wr_pend_q && (wr_addr_q == ADDR_RISE_EN);
   assign wr_fall = wr_pend_q && (wr_addr_q == ADDR_FALL_EN);
   assign wr_flag = wr_pend_q && (wr_addr_q == ADDR_PIN_FLAGS);
   assign wr_stat = wr_pend_q && (wr_addr_q == ADDR_IRQ_STATUS);
   assign wr_mask = wr_pend_q && (wr_addr_q == ADDR_IRQ_MASK);

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------
   // Both port B buffers are synchronised before the select, so a change of the
   // threshold bit never lets an unsynchronised pad value reach the read path
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         b_ttl_meta_q <= '0;
         b_ttl_sync_q <= '0;
      end
      else if (clk_en)
      begin
         b_ttl_meta_q <= portb_ttl_in;
         b_ttl_sync_q <= b_ttl_meta_q;
      end
   end

   // Schmitt buffer path, same two stages as the TTL path
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         b_st_meta_q <= '0;
         b_st_sync_q <= '0;
      end
      else if (clk_en)
      begin
         b_st_meta_q <= portb_st_in;
         b_st_sync_q <= b_st_meta_q;
      end
   end

   // Threshold select steers which synchronised buffer feeds the port B read value
   assign b_sel = (thr_q & b_st_sync_q) | (~thr_q & b_ttl_sync_q);

   // Port C: two flops per pin, then one more that keeps the previous sample
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         c_meta_q <= '0;
         c_sync_q <= '0;
         c_prev_q <= '0;
      end
      else if (clk_en)
      begin
         c_meta_q <= portc_in;
         c_sync_q <= c_meta_q;
         c_prev_q <= c_sync_q;
      end
   end

   // Per-pin edge qualify against its own enables
   for (genvar i = 0; i < PINS; i++)
   begin : g_pin
      assign edge_hit[i] = ( rise_q[i] &  c_sync_q[i] & ~c_prev_q[i])
                         | ( fall_q[i] & ~c_sync_q[i] &  c_prev_q[i]);
   end
   assign edge_any = |edge_hit;

   // ---------------------------------------------------------------
   // Flags: a new edge wins over a clear in the same cycle
   // ---------------------------------------------------------------
   assign flag_d = (flag_q & ~(wr_flag ? wd : '0)) | edge_hit;
   assign stat_d = (stat_q & ~(wr_stat ? wd[0:0] : 1'h0)) | edge_any;

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         thr_q  <= THRESHOLD_RESET;
         drv_q  <= STRONG_DRIVE_RESET;
         rise_q <= EDGE_EN_RESET;
         fall_q <= EDGE_EN_RESET;
         mask_q <= MASK_RESET;
      end
      else if (clk_en)
      begin
         if (wr_thr)
            thr_q <= wd;
         if (wr_drv)
            drv_q <= wd & STRONG_DRIVE_MASK;
         if (wr_rise)
            rise_q <= wd & PORTC_IMPL_MASK;
         if (wr_fall)
            fall_q <= wd & PORTC_IMPL_MASK;
         if (wr_mask)
            mask_q <= wd[0:0];
      end
   end

   // Sticky flags; the outputs load the same next value so they never lag the registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         flag_q               <= FLAGS_RESET;
         stat_q               <= STAT_RESET;
         pin_change_flag      <= FLAGS_RESET;
         change_summary_flag  <= |FLAGS_RESET;
      end
      else if (clk_en)
      begin
         flag_q               <= flag_d;
         stat_q               <= stat_d;
         pin_change_flag      <= flag_d;
         change_summary_flag  <= |flag_d;
      end
   end

   // Interrupt level; a mask change takes effect one cycle after its write lands
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_q <= |(STAT_RESET & MASK_RESET);
      else if (clk_en)
         irq_q <= |(stat_d & mask_q);
   end

   // Pad controls and port B read value, registered so the pads see clean levels
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         portb_threshold_sel  <= THRESHOLD_RESET;
         pin1_strong_drive_en <= STRONG_DRIVE_RESET[STRONG_DRIVE_BIT];
         portb_data           <= '0;
      end
      else if (clk_en)
      begin
         portb_threshold_sel  <= thr_q;
         pin1_strong_drive_en <= drv_q[STRONG_DRIVE_BIT];
         portb_data           <= b_sel;
      end
   end

   // ---------------------------------------------------------------
   // Bus slave: zero wait states, always OKAY
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end
      else if (clk_en)
      begin
         wr_pend_q <= a_ok && hwrite;
         wr_addr_q <= haddr;
      end
   end

   // Handshake outputs from flops; the slave never stalls and never errors
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ready_q <= HREADY_ON;
         resp_q  <= HRESP_OKAY;
      end
      else if (clk_en)
      begin
         ready_q <= HREADY_ON;
         resp_q  <= HRESP_OKAY;
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb
   begin
      rd_sel = '0;
      case (haddr)
         ADDR_THRESHOLD_SEL: rd_sel = thr_q;
         ADDR_STRONG_DRIVE:  rd_sel = drv_q & STRONG_DRIVE_MASK;
         ADDR_RISE_EN:       rd_sel = rise_q & PORTC_IMPL_MASK;
         ADDR_FALL_EN:       rd_sel = fall_q & PORTC_IMPL_MASK;
         ADDR_PIN_FLAGS:     rd_sel = flag_q;
         ADDR_IRQ_STATUS:    rd_sel = {{(PINS-STAT_W){1'b0}}, stat_q};
         ADDR_IRQ_MASK:      rd_sel = {{(PINS-STAT_W){1'b0}}, mask_q};
         ADDR_PIN_STATE:     rd_sel = c_sync_q;
         default:            rd_sel = '0;
      endcase
   end
   assign rdata_d = do_rd ? {24'h000000, rd_sel} : 32'h00000000;

   // Read data captured at the address edge so it stands for the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rdata_q <= '0;
      else if (clk_en)
         rdata_q <= rdata_d;
   end

   assign hrdata    = rdata_q;
   assign hreadyout = ready_q;
   assign hresp     = resp_q;
   assign irq       = irq_q;

endmodule

// ---- pkg/pad_ioc_pkg.sv ----
// Package: register map, field layouts and reset values of the port pad and change-detect block
package pad_ioc_pkg;

   // ---------------------------------------------------------------
   // Register byte addresses (one aligned word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_THRESHOLD_SEL  = 8'h00;
   localparam logic [7:0] ADDR_STRONG_DRIVE   = 8'h04;
   localparam logic [7:0] ADDR_RISE_EN        = 8'h08;
   localparam logic [7:0] ADDR_FALL_EN        = 8'h0c;
   localparam logic [7:0] ADDR_PIN_FLAGS      = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK       = 8'h18;
   localparam logic [7:0] ADDR_PIN_STATE      = 8'h1c;

   // ---------------------------------------------------------------
   // Field layouts and reset values
   // ---------------------------------------------------------------
   localparam int         REG_W               = 8;
   localparam logic [7:0] THRESHOLD_RESET     = 8'hff;
   localparam logic [7:0] STRONG_DRIVE_RESET  = 8'h00;
   localparam logic [7:0] STRONG_DRIVE_MASK   = 8'h02;   // Only bit 1 exists
   localparam int         STRONG_DRIVE_BIT    = 1;
   localparam logic [7:0] EDGE_EN_RESET       = 8'h00;
   localparam logic [7:0] PORTC_IMPL_MASK     = 8'hdf;   // Bit 5 has no change detect
   localparam logic [7:0] FLAGS_RESET         = 8'h00;
   localparam int         STAT_W              = 1;
   localparam int         STAT_SUMMARY_BIT    = 0;
   localparam logic [0:0] STAT_RESET          = 1'h0;
   localparam logic [0:0] MASK_RESET          = 1'h0;

   // ---------------------------------------------------------------
   // AHB-Lite encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ       = 2'h2;
   localparam logic [1:0] HTRANS_SEQ          = 2'h3;
   localparam logic [2:0] HSIZE_WORD          = 3'h2;
   localparam logic [1:0] ADDR_LSB_ZERO       = 2'h0;
   localparam logic       HREADY_ON           = 1'b1;    // Slave never stalls
   localparam logic       HRESP_OKAY          = 1'b0;    // Only response given

endpackage

// ---- test/pad_ioc_assertions.sv ----
// Checker: concurrent assertions on the ports of the pad and change-detect block
`timescale 1ns/1ps
module pad_ioc_assertions
   import pad_ioc_pkg::*;
#(
   parameter int PINS = 8                       // Pins per port
)
(
   input wire logic              hclk,          // Clock
   input wire logic              hresetn,       // Reset, active low
   input wire logic              hsel,          // Slave select
   input wire logic [7:0]        haddr,         // Byte address
   input wire logic [1:0]        htrans,        // Transfer type
   input wire logic              hwrite,        // Write
   input wire logic [2:0]        hsize,         // Size
   input wire logic              hready,        // Bus ready
   input wire logic [31:0]       hwdata,        // Write data
   input wire logic [31:0]       hrdata,        // Read data
   input wire logic [PINS-1:0]   portc_in,      // Port C pads
   input wire logic [PINS-1:0]   portb_threshold_sel, // Threshold out
   input wire logic              pin1_strong_drive_en, // Drive out
   input wire logic [PINS-1:0]   pin_change_flag,     // Flags
   input wire logic              change_summary_flag  // Summary
);
   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   logic            act_q;
   logic            wr_q;
   logic [7:0]      adr_q;
   logic [PINS-1:0] pc_q;
   logic [PINS-1:0] h_q [5];
   wire take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD) & (haddr[1:0] == ADDR_LSB_ZERO);
   wire rd_ph = act_q & ~wr_q;
   wire fw = act_q & wr_q & (adr_q == ADDR_PIN_FLAGS);
   // Pad changes of the last few edges; sync depth is unseen, so allow some slack
   wire [PINS-1:0] recent = h_q[0] | h_q[1] | h_q[2] | h_q[3] | h_q[4] | (portc_in ^ pc_q);

   // Track the data phase and the pad change history
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         act_q <= 1'b0;
         wr_q  <= 1'b0;
         adr_q <= 8'h00;
         pc_q  <= '0;
         h_q   <= '{default: '0};
      end
      else
      begin
         act_q <= take;
         wr_q  <= hwrite;
         adr_q <= haddr;
         pc_q  <= portc_in;
         h_q   <= '{portc_in ^ pc_q, h_q[0], h_q[1], h_q[2], h_q[3]};
      end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_RD_IDLE_ZERO: assert property ((rd_ph ? hrdata[31:8] : hrdata) == '0)
      else $error("read data not zero outside data phase or in upper bits");
   AST_STRONG_RD: assert property (rd_ph && adr_q == ADDR_STRONG_DRIVE |-> (hrdata & ~32'h2) == '0)
      else $error("unimplemented drive bits read nonzero");
   AST_EDGE_BIT5: assert property (rd_ph && (adr_q == ADDR_RISE_EN || adr_q == ADDR_FALL_EN) |-> !hrdata[5])
      else $error("edge enable bit 5 reads one");
   AST_THR_OUT: assert property (act_q && wr_q && adr_q == ADDR_THRESHOLD_SEL |-> ##2 portb_threshold_sel == $past(hwdata[7:0], 2))
      else $error("threshold output does not follow write");
   AST_DRIVE_OUT: assert property (act_q && wr_q && adr_q == ADDR_STRONG_DRIVE |-> ##2 pin1_strong_drive_en == $past(hwdata[1], 2))
      else $error("strong drive output does not follow bit 1");
   AST_FLAG_STICKY: assert property (|($past(pin_change_flag) & ~pin_change_flag) |-> $past(fw) || $past(fw, 2) || $past(fw, 3))
      else $error("flag fell without a clear write");
   AST_SUMMARY_OR: assert property (change_summary_flag == (|pin_change_flag))
      else $error("summary flag differs from OR of flags");
   AST_FLAG_CAUSE: assert property ((pin_change_flag & ~$past(pin_change_flag) & ~recent) == '0)
      else $error("flag set without a recent pad change");
endmodule

// ---- test/tb_pad_ioc.sv ----
// Testbench: registers, pad controls and change detection of the pad block
`timescale 1ns/1ps
module tb_pad_ioc;
   import pad_ioc_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin1, summ, irq, m_stat;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  haddr, ttl, st, pc, bdata, thr_o, flags, m_flags, ev, old;
   logic [31:0] hwdata, hrdata, rd_v, seed, t;
   int          n_fail, compares, cyc;
   localparam logic [7:0] RA [8] = '{ADDR_THRESHOLD_SEL, ADDR_STRONG_DRIVE, ADDR_RISE_EN, ADDR_FALL_EN,
                                     ADDR_PIN_FLAGS, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, 8'h24};

   pad_ioc #(.PINS(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .portb_ttl_in(ttl), .portb_st_in(st), .portc_in(pc),
      .portb_data(bdata), .portb_threshold_sel(thr_o), .pin1_strong_drive_en(pin1),
      .pin_change_flag(flags), .change_summary_flag(summ), .irq(irq));

   // ---------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ---------------------------------------------------------------
   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // A hang counts as a mismatch
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         n_fail++;
         end_sim();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One single transfer; the leading edge gives the idle cycle a read-back needs
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_v = hrdata;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(nm, e, rd_v);
      chk("hresp", 32'h0, 32'(hresp));
   endtask

   task automatic end_sim();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, ttl, st, pc} = '0;
      hsize = HSIZE_WORD;
      seed = 32'h6e59;
      {m_stat, m_flags} = '0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(8'h24, 1'b1, 32'hffffffff);
      foreach (RA[i]) rdc("reset", RA[i], (i == 0) ? 32'(THRESHOLD_RESET) : 32'h0);
      // Pad controls against random buffer values
      repeat (4)
      begin
         t = xs();
         xfer(ADDR_THRESHOLD_SEL, 1'b1, t);
         xfer(ADDR_STRONG_DRIVE, 1'b1, ~t);
         {ttl, st} <= 16'(xs());
         rdc("threshold", ADDR_THRESHOLD_SEL, t & 32'hff);
         rdc("strong", ADDR_STRONG_DRIVE, ~t & 32'h2);
         repeat (6) @(posedge hclk);
         chk("sel_out", 32'(t[7:0]), 32'(thr_o));
         chk("pin1", {31'h0, ~t[1]}, 32'(pin1));
         chk("portb", 32'((st & t[7:0]) | (ttl & ~t[7:0])), 32'(bdata));
      end
      // Edge detection; early flags must survive until the clearing rounds
      for (int i = 0; i < 6; i++)
      begin
         t = xs();
         xfer(ADDR_RISE_EN, 1'b1, t);
         xfer(ADDR_FALL_EN, 1'b1, t >> 8);
         rdc("rise_en", ADDR_RISE_EN, t & 32'hdf);
         rdc("fall_en", ADDR_FALL_EN, (t >> 8) & 32'hdf);
         old = pc;
         pc <= t[23:16];
         repeat (6) @(posedge hclk);
         ev = ((t[7:0] & ~old & t[23:16]) | (t[15:8] & old & ~t[23:16])) & PORTC_IMPL_MASK;
         m_flags = m_flags | ev;
         m_stat = m_stat | (ev != 8'h00);
         chk("flags", 32'(m_flags), 32'(flags));
         chk("summary", 32'(m_flags != 8'h00), 32'(summ));
         rdc("pin_state", ADDR_PIN_STATE, 32'(pc));
         xfer(ADDR_IRQ_MASK, 1'b1, 32'(i & 1));
         rdc("status", ADDR_IRQ_STATUS, 32'(m_stat));
         chk("irq", 32'(m_stat & i[0]), 32'(irq));
         if (i > 2)
         begin
            xfer(ADDR_PIN_FLAGS, 1'b1, 32'hff);
            xfer(ADDR_IRQ_STATUS, 1'b1, 32'h1);
            {m_stat, m_flags} = '0;
            rdc("flags_clr", ADDR_PIN_FLAGS, 32'h0);
            chk("irq_clr", 32'h0, 32'(irq));
            chk("summary_clr", 32'h0, 32'(summ));
         end
      end
      end_sim();
   end
endmodule

bind pad_ioc pad_ioc_assertions #(.PINS(PINS)) chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .portc_in(portc_in), .portb_threshold_sel(portb_threshold_sel),
   .pin1_strong_drive_en(pin1_strong_drive_en), .pin_change_flag(pin_change_flag),
   .change_summary_flag(change_summary_flag));
